// ===== shared/svc_regs.vh
// Register offsets, fields, reset values and timing for supervisor sleep control
`ifndef SVC_REGS_VH
`define SVC_REGS_VH

`define SVC_ADDR_CONFIG      8'h00
`define SVC_ADDR_BORCTL      8'h04
`define SVC_ADDR_REGCTL      8'h08
`define SVC_ADDR_DOZE        8'h0C
`define SVC_ADDR_STATUS      8'h10
`define SVC_ADDR_CTRL        8'h14

`define SVC_CFG_STACKRST     12
`define SVC_CFG_MODE_HI      7
`define SVC_CFG_MODE_LO      6
`define SVC_CFG_LPBOR_N      5
`define SVC_CFG_POWERUP_DELAY_HI      2
`define SVC_CFG_POWERUP_DELAY_LO      1
`define SVC_CFG_MASTER_CLEAR_PIN_ENABLE        0

`define SVC_BOR_SWEN         7
`define SVC_BOR_READY        0
`define SVC_REG_LOWPWR       1
`define SVC_REG_FIXED1       0
`define SVC_DOZE_IDLE        7

`define SVC_ST_PD            0
`define SVC_ST_TO            1
`define SVC_ST_SLEEP         2
`define SVC_ST_IDLE          3
`define SVC_ST_ADCBAD        4
`define SVC_ST_BORRST        5
`define SVC_ST_STKRST        6
`define SVC_ST_MCLRRST       7

`define SVC_CTRL_SLEEP       0
`define SVC_CTRL_WAKE        1
`define SVC_CTRL_CLRFLAGS    2

`define SVC_BORCTL_RESET     8'h80
`define SVC_REGCTL_RESET     8'h01

`define SVC_MODE_ON          2'b11
`define SVC_MODE_RUN         2'b10
`define SVC_MODE_SW          2'b01
`define SVC_MODE_OFF         2'b00

`define SVC_POWERUP_DELAY_1MS_US      1000
`define SVC_POWERUP_DELAY_16MS_US     16000
`define SVC_POWERUP_DELAY_64MS_US     64000
`define SVC_CLK_MHZ          125

`endif

// ===== src/svc_delay_rom.v
// Registered lookup of power-up delay lengths in clock cycles
`timescale 1ns/1ps
`include "svc_regs.vh"
module svc_delay_rom #(
    parameter CNT_W   = 24,
    parameter CYC_1   = 125000,
    parameter CYC_16  = 2000000,
    parameter CYC_64  = 8000000
) (
    input  wire             clk,
    input  wire             arst_n,
    input  wire [1:0]       sel,
    output reg  [CNT_W-1:0] cycles
);
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cycles <= {CNT_W{1'b0}};
        else
            case (sel)
                2'b00: cycles <= CYC_1[CNT_W-1:0];
                2'b01: cycles <= CYC_16[CNT_W-1:0];
                2'b10: cycles <= CYC_64[CNT_W-1:0];
                default: cycles <= {CNT_W{1'b0}};
            endcase
    end
endmodule

// ===== src/svc_supervisor.v
// Supervisor, brown-out control and sleep entry logic with Wishbone registers
//
// Contract
// R1: Decode two-bit brown-out mode field
// R2: Software enable ignored unless mode 01
// R3: Mode 01 follows software enable bit
// R4: Ready flag bit 0 shows active
// R5: Power-up delay select: off,64,16,1 ms
// R6: Low-power brown-out enable is active low
// R7: Stack fault resets when enabled
// R8: Master-clear pin function select
// R9: Sleep only when idle select clear
// R10: Idle select set gives idle mode
// R11: Sleep clears watchdog, keeps running optionally
// R12: Sleep clears power-down, sets time-out flag
// R13: Oscillators keep running in sleep
// R14: ADC dedicated-osc continues, else abandoned
// R15: Ports hold pre-sleep drive in sleep; pins set in asyncOwn follow live inputs instead
// R16: Other resets unaffected by sleep
// R17: Regulator low-power bit selects sleep mode
// R18: Software keeps regulator bit 0 set
// R19: Brown-out reset held through power-up delay
// R20: Configuration sampled at reset release
`timescale 1ns/1ps
`include "svc_regs.vh"
module svc_supervisor #(
    parameter CNT_W   = 24,
    parameter CYC_1   = (`SVC_POWERUP_DELAY_1MS_US * `SVC_CLK_MHZ),
    parameter CYC_16  = (`SVC_POWERUP_DELAY_16MS_US * `SVC_CLK_MHZ),
    parameter CYC_64  = (`SVC_POWERUP_DELAY_64MS_US * `SVC_CLK_MHZ),
    parameter PORT_W  = 8
) (
    input  wire              clk,
    input  wire              arst_n,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [31:0]       wb_dat_i,
    input  wire [3:0]        wb_sel_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    input  wire [13:0]       configWord,
    input  wire              lowVoltageProgEnable,
    input  wire              brownoutLow,
    input  wire              masterClearPin,
    input  wire              stackFault,
    input  wire              watchdogSleepRun,
    input  wire              adcBusy,
    input  wire              adcDedicatedOsc,
    input  wire [PORT_W-1:0] portDriveIn,
    input  wire [PORT_W-1:0] portOeIn,
    input  wire [PORT_W-1:0] asyncOwn,
    output reg               brownoutReset,
    output reg               stackReset,
    output reg               masterClearReset,
    output reg               portG5Input,
    output reg               ultraLowPowerBrownout,
    output reg               sleepActive,
    output reg               idleActive,
    output reg               watchdogClear,
    output reg               watchdogRun,
    output reg               adcAbort,
    output reg               regulatorLowPower,
    output reg               oscKeepRun,
    output reg  [PORT_W-1:0] portDriveOut,
    output reg  [PORT_W-1:0] portOeOut
);
    localparam RUN   = 2'd0;
    localparam SLEEP = 2'd1;
    localparam IDLE  = 2'd2;
    localparam [7:0] BORCTL_RST = `SVC_BORCTL_RESET;

    reg  [13:0]      cfg_reg;
    reg              cfgLoaded_reg;
    reg              swEn_reg;
    reg              regLp_reg;
    reg              idleSel_reg;
    reg  [7:0]       status_reg;
    reg  [1:0]       state_reg;
    reg  [1:0]       state_next;
    reg  [CNT_W-1:0] delay_reg;
    reg              borHold_reg;
    reg  [2:0]       borSync_reg;
    reg  [2:0]       mclrSync_reg;
    reg              borLow_reg;
    reg              master_clear_pin_reg;
    wire [CNT_W-1:0] delayCycles;
    wire [1:0]       mode;
    wire             borEnabled;
    wire             wbReq;
    wire             wbWr;
    wire             sleepCmd;
    wire             wakeCmd;
    wire             clrCmd;
    wire             mclrIsReset;

    function bor_enable;
        input [1:0] m;
        input       sw;
        input       asleep;
        begin
            case (m)
                `SVC_MODE_ON:  bor_enable = 1'b1;
                `SVC_MODE_RUN: bor_enable = !asleep;
                `SVC_MODE_SW:  bor_enable = sw;
                default:       bor_enable = 1'b0;
            endcase
        end
    endfunction

    svc_delay_rom #(
        .CNT_W  (CNT_W),
        .CYC_1  (CYC_1),
        .CYC_16 (CYC_16),
        .CYC_64 (CYC_64)
    ) u_rom (
        .clk    (clk),
        .arst_n (arst_n),
        .sel    (cfg_reg[`SVC_CFG_POWERUP_DELAY_HI:`SVC_CFG_POWERUP_DELAY_LO]),
        .cycles (delayCycles)
    );

    assign mode = cfg_reg[`SVC_CFG_MODE_HI:`SVC_CFG_MODE_LO];
    // R1: mode decode
    // R2: swEn only matters in mode 01
    // R3: software controlled mode
    assign borEnabled = cfgLoaded_reg && bor_enable(mode, swEn_reg, state_reg == SLEEP);
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
    assign sleepCmd = wbWr && (wb_adr_i == `SVC_ADDR_CTRL) && wb_dat_i[`SVC_CTRL_SLEEP];
    assign wakeCmd = wbWr && (wb_adr_i == `SVC_ADDR_CTRL) && wb_dat_i[`SVC_CTRL_WAKE];
    assign clrCmd = wbWr && (wb_adr_i == `SVC_ADDR_CTRL) && wb_dat_i[`SVC_CTRL_CLRFLAGS];
    // R8: low-voltage programming forces reset function
    assign mclrIsReset = lowVoltageProgEnable || cfg_reg[`SVC_CFG_MASTER_CLEAR_PIN_ENABLE];

    // R20: capture configuration once after release
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_reg <= 14'h3FFF;
            cfgLoaded_reg <= 1'b0;
        end
        else if (!cfgLoaded_reg)
        begin
            cfg_reg <= configWord;
            cfgLoaded_reg <= 1'b1;
        end
    end

    // Pin inputs settle over three stages
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            borSync_reg <= 3'b000;
            mclrSync_reg <= 3'b111;
            borLow_reg <= 1'b0;
            master_clear_pin_reg <= 1'b1;
        end
        else
        begin
            borSync_reg <= {borSync_reg[1:0], brownoutLow};
            mclrSync_reg <= {mclrSync_reg[1:0], masterClearPin};
            if (borSync_reg[2] == borSync_reg[1])
                borLow_reg <= borSync_reg[2];
            if (mclrSync_reg[2] == mclrSync_reg[1])
                master_clear_pin_reg <= mclrSync_reg[2];
        end
    end

    // R9: sleep versus idle choice
    // R10: idle when select set
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            RUN:
                if (sleepCmd)
                    state_next = idleSel_reg ? IDLE : SLEEP;
            SLEEP, IDLE:
                if (wakeCmd)
                    state_next = RUN;
            default:
                state_next = RUN;
        endcase
    end

    // R19: hold reset until delay after recovery
    // R16: stack and master-clear reset paths ignore sleep state; brown-out mode 10 is off in sleep
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            delay_reg <= {CNT_W{1'b0}};
            borHold_reg <= 1'b0;
        end
        else if (borEnabled && borLow_reg)
        begin
            borHold_reg <= 1'b1;
            delay_reg <= delayCycles;
        end
        else if (borHold_reg)
        begin
            // R5: delay zero when timer disabled
            if (delay_reg == {CNT_W{1'b0}})
                borHold_reg <= 1'b0;
            else
                delay_reg <= delay_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= RUN;
            swEn_reg <= BORCTL_RST[`SVC_BOR_SWEN];
            regLp_reg <= 1'b0;
            idleSel_reg <= 1'b0;
            status_reg <= 8'h01;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            wb_ack_o <= wbReq;
            if (wbWr && wb_adr_i == `SVC_ADDR_BORCTL)
                swEn_reg <= wb_dat_i[`SVC_BOR_SWEN];
            if (wbWr && wb_adr_i == `SVC_ADDR_REGCTL)
                regLp_reg <= wb_dat_i[`SVC_REG_LOWPWR];
            if (wbWr && wb_adr_i == `SVC_ADDR_DOZE)
                idleSel_reg <= wb_dat_i[`SVC_DOZE_IDLE];
            // Hardware set wins over software clear
            if (clrCmd)
                status_reg[7:2] <= 6'h00;
            status_reg[`SVC_ST_SLEEP] <= (state_next == SLEEP);
            status_reg[`SVC_ST_IDLE] <= (state_next == IDLE);
            // R12: flags on sleep entry
            if (state_reg == RUN && state_next == SLEEP)
            begin
                status_reg[`SVC_ST_PD] <= 1'b0;
                status_reg[`SVC_ST_TO] <= 1'b1;
                // R14: abandoned conversion flagged invalid
                if (adcBusy && !adcDedicatedOsc)
                    status_reg[`SVC_ST_ADCBAD] <= 1'b1;
            end
            else if (clrCmd)
                status_reg[1:0] <= 2'b01;
            if (brownoutReset)
                status_reg[`SVC_ST_BORRST] <= 1'b1;
            if (stackReset)
                status_reg[`SVC_ST_STKRST] <= 1'b1;
            if (masterClearReset)
                status_reg[`SVC_ST_MCLRRST] <= 1'b1;
            wb_dat_o <= 32'h0000_0000;
            if (wbReq && !wb_we_i)
                case (wb_adr_i)
                    `SVC_ADDR_CONFIG: wb_dat_o <= {18'h00000, cfg_reg};
                    // R4: ready flag reflects live circuit
                    `SVC_ADDR_BORCTL: wb_dat_o <= {24'h000000, swEn_reg, 6'h00, borEnabled};
                    // R18: bit 0 reads back as one
                    `SVC_ADDR_REGCTL: wb_dat_o <= {24'h000000, 6'h00, regLp_reg, 1'b1};
                    `SVC_ADDR_DOZE:   wb_dat_o <= {24'h000000, idleSel_reg, 7'h00};
                    `SVC_ADDR_STATUS: wb_dat_o <= {24'h000000, status_reg};
                    default:          wb_dat_o <= 32'h0000_0000;
                endcase
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            brownoutReset <= 1'b0;
            stackReset <= 1'b0;
            masterClearReset <= 1'b0;
            portG5Input <= 1'b1;
            ultraLowPowerBrownout <= 1'b0;
            sleepActive <= 1'b0;
            idleActive <= 1'b0;
            watchdogClear <= 1'b0;
            watchdogRun <= 1'b1;
            adcAbort <= 1'b0;
            regulatorLowPower <= 1'b0;
            oscKeepRun <= 1'b1;
            portDriveOut <= {PORT_W{1'b0}};
            portOeOut <= {PORT_W{1'b0}};
        end
        else
        begin
            brownoutReset <= borHold_reg || (borEnabled && borLow_reg);
            // R7: stack fault reset gate
            stackReset <= cfg_reg[`SVC_CFG_STACKRST] && stackFault && cfgLoaded_reg;
            // R8: pin is reset or plain input
            masterClearReset <= mclrIsReset && !master_clear_pin_reg;
            portG5Input <= mclrIsReset ? 1'b1 : master_clear_pin_reg;
            // R6: active-low enable bit
            ultraLowPowerBrownout <= cfgLoaded_reg && !cfg_reg[`SVC_CFG_LPBOR_N];
            sleepActive <= (state_next == SLEEP);
            idleActive <= (state_next == IDLE);
            // R11: clear watchdog on entry
            watchdogClear <= (state_reg == RUN) && (state_next == SLEEP);
            watchdogRun <= (state_next != SLEEP) || watchdogSleepRun;
            // R14: stop only system-clocked conversion
            adcAbort <= (state_reg == RUN) && (state_next == SLEEP)
                        && adcBusy && !adcDedicatedOsc;
            // R17: regulator mode applies in sleep
            regulatorLowPower <= regLp_reg && (state_next == SLEEP);
            // R13: oscillators never stopped here
            oscKeepRun <= 1'b1;
            // R15: freeze ports unless peripheral owns them
            if (state_next != SLEEP)
            begin
                portDriveOut <= portDriveIn;
                portOeOut <= portOeIn;
            end
            else
            begin
                portDriveOut <= (portDriveOut & ~asyncOwn) | (portDriveIn & asyncOwn);
                portOeOut <= (portOeOut & ~asyncOwn) | (portOeIn & asyncOwn);
            end
        end
    end
endmodule

// ===== dv/svc_supervisor_monitor.sv
// Concurrent port checks for the supervisor sleep control block
`timescale 1ns/1ps
module svc_supervisor_monitor #(
    parameter PORT_W = 8
) (
    input wire              clk,
    input wire              arst_n,
    input wire              wb_cyc_i,
    input wire              wb_stb_i,
    input wire              wb_ack_o,
    input wire [31:0]       wb_dat_o,
    input wire [13:0]       configWord,
    input wire              brownoutLow,
    input wire              stackFault,
    input wire              stackReset,
    input wire              brownoutReset,
    input wire              sleepActive,
    input wire              idleActive,
    input wire              watchdogClear,
    input wire              oscKeepRun,
    input wire              regulatorLowPower,
    input wire              adcBusy,
    input wire              adcDedicatedOsc,
    input wire              adcAbort,
    input wire [PORT_W-1:0] portDriveOut,
    input wire [PORT_W-1:0] asyncOwn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence lowHeld;
        brownoutLow [*6];
    endsequence
    sequence sleepEntry;
        $rose(sleepActive);
    endsequence

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    osc_run_a: assert property (oscKeepRun) else $error("oscillator stopped");
    mode_excl_a: assert property (!(sleepActive && idleActive)) else $error("sleep and idle");
    reg_lowpwr_a: assert property (regulatorLowPower |-> sleepActive) else $error("low power awake");
    wd_clear_a: assert property (sleepEntry |-> watchdogClear) else $error("watchdog not cleared");
    stack_rst_a: assert property (stackFault && configWord[12] |-> ##[1:4] stackReset)
        else $error("stack fault without reset");
    bor_on_a: assert property (lowHeld ##0 configWord[7:6] == 2'b11 |-> ##[0:2] brownoutReset)
        else $error("brown-out reset missing");
    bor_off_a: assert property (configWord[7:6] == 2'b00 |-> !brownoutReset)
        else $error("brown-out reset while disabled");
    adc_abort_a: assert property (sleepEntry |-> adcAbort == $past(adcBusy && !adcDedicatedOsc))
        else $error("adc abort mismatch at sleep entry");
    port_hold_a: assert property (sleepActive && $past(sleepActive) |->
        ((portDriveOut ^ $past(portDriveOut)) & ~asyncOwn) == 0) else $error("port moved in sleep");
endmodule

bind svc_supervisor svc_supervisor_monitor #(.PORT_W(PORT_W)) u_mon (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .configWord(configWord), .brownoutLow(brownoutLow),
    .stackFault(stackFault), .stackReset(stackReset), .brownoutReset(brownoutReset),
    .sleepActive(sleepActive), .idleActive(idleActive), .watchdogClear(watchdogClear),
    .oscKeepRun(oscKeepRun), .regulatorLowPower(regulatorLowPower),
    .adcBusy(adcBusy), .adcDedicatedOsc(adcDedicatedOsc), .adcAbort(adcAbort),
    .portDriveOut(portDriveOut), .asyncOwn(asyncOwn));

// ===== dv/svc_supervisor_bench.sv
// Self-checking bench for the supervisor sleep control block
`timescale 1ns/1ps
`include "svc_regs.vh"
module svc_supervisor_bench;
    logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00, pIn = 8'h00, pOe = 8'h00, aOwn = 8'h00, pv, ov, pOut, pOeO;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [13:0] cfg = 14'h3FFF, c;
    logic        low_voltage_prog_enable = 1'b0, bLow = 1'b0, mPin = 1'b1, stkF = 1'b0, wdRun = 1'b0;
    logic        adcBusy = 1'b0, adcFrc = 1'b0, ack, borRst, stkRst, mRst, g5, ulp;
    logic        slp, idl, wdRunO, regLp;
    logic [1:0]  md, pw;
    integer      errors = 0, compares = 0, seed = 32'h6EA1, i, n;

    always #4 clk = ~clk;

    svc_supervisor #(.CYC_1(10), .CYC_16(20), .CYC_64(40)) u_dut (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
        .configWord(cfg), .lowVoltageProgEnable(low_voltage_prog_enable), .brownoutLow(bLow),
        .masterClearPin(mPin), .stackFault(stkF), .watchdogSleepRun(wdRun),
        .adcBusy(adcBusy), .adcDedicatedOsc(adcFrc), .portDriveIn(pIn), .portOeIn(pOe),
        .asyncOwn(aOwn), .brownoutReset(borRst), .stackReset(stkRst),
        .masterClearReset(mRst), .portG5Input(g5), .ultraLowPowerBrownout(ulp),
        .sleepActive(slp), .idleActive(idl), .watchdogClear(), .watchdogRun(wdRunO),
        .adcAbort(), .regulatorLowPower(regLp), .oscKeepRun(), .portDriveOut(pOut),
        .portOeOut(pOeO));

    function automatic logic borOn(input logic [1:0] m, input logic sw, input logic asl);
        borOn = (m == 2'b11) || (m == 2'b10 && !asl) || (m == 2'b01 && sw);
    endfunction

    function automatic integer dly(input logic [1:0] p);
        dly = (p == 2'b11) ? 0 : (p == 2'b10) ? 40 : (p == 2'b01) ? 20 : 10;
    endfunction

    task test_done;
        begin
            $display("compares %0d errors %0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
            end
        end
    endtask

    // Holds the request until ack is sampled, then releases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk);
            // Only the watchdog ends a wait for ack
            while (ack !== 1'b1)
                @(posedge clk);
            q = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
        begin
            bus(1'b0, a, 32'h0);
            chk(q, e, m);
        end
    endtask

    task automatic stk(input logic e);
        begin
            stkF <= 1'b1;
            repeat (3) @(posedge clk);
            chk(stkRst, e, "stack reset");
            stkF <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errors = errors + 1;
        test_done;
    end

    initial
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            md = i[1:0] ^ 2'b11;
            pw = md ^ 2'b10;
            c = 14'($random(seed));
            c[7:6] = md;
            c[2:1] = pw;
            @(posedge clk);
            arst_n <= 1'b0;
            cfg <= c;
            low_voltage_prog_enable <= i[1];
            repeat (3) @(posedge clk);
            arst_n <= 1'b1;
            repeat (5) @(posedge clk);
            rdchk(`SVC_ADDR_CONFIG, {18'h0, c}, "config");
            bus(1'b1, `SVC_ADDR_CONFIG, {18'h0, ~c});
            rdchk(`SVC_ADDR_CONFIG, {18'h0, c}, "config kept");
            rdchk(`SVC_ADDR_BORCTL, {24'h0, 7'h40, borOn(md, 1'b1, 1'b0)}, "ready");
            bus(1'b1, `SVC_ADDR_BORCTL, 32'h0);
            rdchk(`SVC_ADDR_BORCTL, {31'h0, borOn(md, 1'b0, 1'b0)}, "sw enable");
            bus(1'b1, `SVC_ADDR_BORCTL, 32'h80);
            rdchk(`SVC_ADDR_REGCTL, 32'h1, "regulator");
            rdchk(`SVC_ADDR_STATUS, 32'h1, "status");
            rdchk(8'h1C, 32'h0, "unmapped");
            chk(ulp, !c[5], "ulp");
            stk(c[12]);
            // Clear flags first so the status byte is fully known
            bus(1'b1, `SVC_ADDR_CTRL, 32'h4);
            adcBusy <= 1'b1;
            adcFrc <= 1'($random(seed));
            wdRun <= 1'($random(seed));
            pv = 8'($random(seed));
            ov = 8'($random(seed));
            pIn <= pv;
            pOe <= ov;
            aOwn <= 8'($random(seed));
            bus(1'b1, `SVC_ADDR_REGCTL, 32'h3);
            bus(1'b1, `SVC_ADDR_DOZE, 32'h0);
            bus(1'b1, `SVC_ADDR_CTRL, 32'h1);
            @(posedge clk);
            pIn <= ~pv;
            pOe <= ~ov;
            chk(slp, 1'b1, "sleep");
            chk(regLp, 1'b1, "reg low power");
            chk(wdRunO, wdRun, "watchdog run");
            rdchk(`SVC_ADDR_STATUS, {27'h0, ~adcFrc, 4'h6}, "sleep status");
            rdchk(`SVC_ADDR_REGCTL, 32'h3, "regulator set");
            rdchk(`SVC_ADDR_BORCTL, {24'h0, 7'h40, borOn(md, 1'b1, 1'b1)}, "sleep ready");
            // Owned pins follow the inverted live inputs, the rest stay frozen
            chk(pOut, pv ^ aOwn, "port drive");
            chk(pOeO, ov ^ aOwn, "port enable");
            stk(c[12]);
            bus(1'b1, `SVC_ADDR_CTRL, 32'h2);
            bus(1'b1, `SVC_ADDR_DOZE, 32'h80);
            bus(1'b1, `SVC_ADDR_CTRL, 32'h1);
            @(posedge clk);
            chk({idl, slp}, 2'b10, "idle");
            bus(1'b1, `SVC_ADDR_CTRL, 32'h2);
            adcBusy <= 1'b0;
            mPin <= 1'b0;
            repeat (6) @(posedge clk);
            chk({mRst, g5}, {low_voltage_prog_enable | c[0], low_voltage_prog_enable | c[0]}, "clear pin");
            mPin <= 1'b1;
            repeat (6) @(posedge clk);
            chk({mRst, g5}, 2'b01, "pin high");
            // Brown-out last, since its reset may disturb register state
            bLow <= 1'b1;
            repeat (10) @(posedge clk);
            chk(borRst, borOn(md, 1'b1, 1'b0), "brown-out");
            bLow <= 1'b0;
            n = 0;
            while (borRst === 1'b1 && n < 100)
            begin
                n = n + 1;
                @(posedge clk);
            end
            if (borOn(md, 1'b1, 1'b0))
                chk(n >= dly(pw) && n <= dly(pw) + 8, 1'b1, "delay");
        end
        test_done;
    end
endmodule
